//--- design/pps_pkg.sv
// Constants and types for the pulse port status and frequency readout block
package pps_pkg;

  // ****************************************
  // Clock and sampling windows
  // ****************************************
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned WIN_A_MS = 10;
  localparam int unsigned WIN_B_MS = 100;
  localparam int unsigned WIN_C_MS = 1000;
  // Window lengths in cycles; all exceed 4096 so the top takes them as params
  localparam int unsigned WIN_A_CYC = CLK_HZ / 1000 * WIN_A_MS;
  localparam int unsigned WIN_B_CYC = CLK_HZ / 1000 * WIN_B_MS;
  localparam int unsigned WIN_C_CYC = CLK_HZ / 1000 * WIN_C_MS;
  localparam int unsigned WIN_W = 25;
  localparam int unsigned CNT_W = 18;
  // Scale from pulses per window to pulses per second
  localparam logic [31:0] MULT_A = 32'h0000_0064;
  localparam logic [31:0] MULT_B = 32'h0000_000A;
  localparam logic [31:0] MULT_C = 32'h0000_0001;
  localparam logic [CNT_W-1:0] CNT_CAP = 18'h3_FFFF;

  // ****************************************
  // Frequency ceilings
  // ****************************************
  localparam logic [31:0] FREQ_MAX_STD = 32'h0001_86A0;
  localparam logic [31:0] FREQ_MAX_QUAD = 32'h0003_0D40;
  localparam int unsigned PFREQ_W = 17;

  // ****************************************
  // Port selectors and control codes
  // ****************************************
  localparam logic [15:0] PORT_PLS0 = 16'h0000;
  localparam logic [15:0] PORT_PLS1 = 16'h0001;
  localparam logic [15:0] PORT_HSC0 = 16'h0010;
  localparam logic [15:0] PORT_HSC_LAST = 16'h0015;
  localparam logic [15:0] PORT_PWM = 16'h1000;
  localparam logic [15:0] CODE_PV = 16'h0000;
  localparam logic [15:0] CODE_STAT = 16'h0001;
  localparam logic [15:0] CODE_RANGE = 16'h0002;
  localparam logic [15:0] CODE_FREQ = 16'h0003;
  localparam logic [15:0] CODE_S10 = 16'h0013;
  localparam logic [15:0] CODE_S100 = 16'h0023;
  localparam logic [15:0] CODE_S1S = 16'h0033;

  // ****************************************
  // Register map and field positions
  // ****************************************
  localparam int unsigned APB_AW = 8;
  localparam logic [7:0] ADDR_PORT = 8'h00;
  localparam logic [7:0] ADDR_CODE = 8'h04;
  localparam logic [7:0] ADDR_EXEC = 8'h08;
  localparam logic [7:0] ADDR_DLO = 8'h0C;
  localparam logic [7:0] ADDR_DHI = 8'h10;
  localparam logic [7:0] ADDR_FLAGS = 8'h14;
  localparam int unsigned PST_ACCEL = 0;
  localparam int unsigned PST_OVF = 1;
  localparam int unsigned PST_AMT = 2;
  localparam int unsigned PST_DONE = 3;
  localparam int unsigned PST_ERRSTOP = 4;
  localparam int unsigned PWM_OUT_BIT = 0;
  localparam int unsigned FLAG_ERR_BIT = 0;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [31:0] RST_FREQ = 32'h0000_0000;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {SAMP_10MS, SAMP_100MS, SAMP_1S} pps_samp_t;

  typedef struct packed {
    logic [15:0] port;
    logic [15:0] code;
    logic [15:0] destLo;
    logic [15:0] destHi;
    logic err;
    logic [31:0] rdata;
    logic slverr;
    logic rdOk;
    pps_samp_t samp;
    logic [WIN_W-1:0] winCnt;
    logic [CNT_W-1:0] pulseCnt;
    logic [31:0] freq;
  } pps_state_t;

endpackage : pps_pkg

//--- design/pps_readout.sv
// Pulse port status, range result and frequency readout with APB registers
`timescale 1ns/100ps

module pps_readout #(
  parameter int unsigned NUM_PLS = 2,
  parameter int unsigned NUM_HSC = 6,
  parameter int unsigned HSC_STAT_W = 16,
  parameter int unsigned RANGE_N = 6,
  parameter int unsigned WIN_A = pps_pkg::WIN_A_CYC,
  parameter int unsigned WIN_B = pps_pkg::WIN_B_CYC,
  parameter int unsigned WIN_C = pps_pkg::WIN_C_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic clkEn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pps_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_PLS-1:0] pulseAccel,
  input wire logic [NUM_PLS-1:0] pulseOvf,
  input wire logic [NUM_PLS-1:0] pulseAmtSet,
  input wire logic [NUM_PLS-1:0] pulseDone,
  input wire logic [NUM_PLS-1:0] pulseErrStop,
  input wire logic [NUM_PLS*pps_pkg::PFREQ_W-1:0] pulseFreq,
  input wire logic [NUM_HSC-1:0] hscEnabled,
  input wire logic [NUM_HSC*HSC_STAT_W-1:0] hscStatus,
  input wire logic [NUM_HSC-1:0] hscRangeActive,
  input wire logic [NUM_HSC*RANGE_N-1:0] hscRangeHit,
  input wire logic hscQuad4x,
  input wire logic hscCount,
  input wire logic pwmOut,
  output logic instructionErrorFlag
);
  import pps_pkg::*;

  // ****************************************
  // Per-channel word assembly
  // ****************************************
  logic [15:0] plsWord [NUM_PLS];
  logic [31:0] plsFreqW [NUM_PLS];
  logic [15:0] hscWord [NUM_HSC];
  logic [15:0] rangeWord [NUM_HSC];

  // Pulse output status, counter status and range words per channel
  // Rebuilt every cycle, so a command sees the pins of its own edge
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PLS; gi++) begin : g_pls
      always_comb begin
        plsWord[gi] = RST_WORD;
        plsWord[gi][PST_ACCEL] = pulseAccel[gi];
        plsWord[gi][PST_OVF] = pulseOvf[gi];
        plsWord[gi][PST_AMT] = pulseAmtSet[gi];
        plsWord[gi][PST_DONE] = pulseDone[gi];
        plsWord[gi][PST_ERRSTOP] = pulseErrStop[gi];
        plsFreqW[gi] = 32'h0000_0000;
        plsFreqW[gi][PFREQ_W-1:0] =
          pulseFreq[gi*PFREQ_W +: PFREQ_W];
        // Guard against a generator reporting past its ceiling
        // instead of passing an oversize value on
        if (plsFreqW[gi] > FREQ_MAX_STD) begin
          plsFreqW[gi] = FREQ_MAX_STD;
        end
      end
    end
    // Counter words are padded to 16 bits; unused bits read zero
    for (gi = 0; gi < NUM_HSC; gi++) begin : g_hsc
      always_comb begin
        hscWord[gi] = RST_WORD;
        hscWord[gi][HSC_STAT_W-1:0] =
          hscStatus[gi*HSC_STAT_W +: HSC_STAT_W];
        rangeWord[gi] = RST_WORD;
        rangeWord[gi][RANGE_N-1:0] =
          hscRangeHit[gi*RANGE_N +: RANGE_N];
      end
    end
  endgenerate

  // ****************************************
  // State
  // ****************************************
  // Whole block state; one register keeps every field in step
  pps_state_t s_r;
  pps_state_t s_nxt;

  // Bus answer from registers; a setup cycle lost to a low clock enable
  // costs one wait state, so data shown with pready is never left over
  assign pready = clkEn & s_r.rdOk;
  assign prdata = s_r.rdata;
  // Error shown only in an access phase whose answer has been latched
  assign pslverr = s_r.slverr & s_r.rdOk & psel & penable;
  assign instructionErrorFlag = s_r.err;

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    logic latchNow;
    logic doneAcc;
    logic wrAcc;
    logic execNow;
    logic isPls;
    logic isHsc;
    logic isHsc0;
    logic isPwm;
    logic isSamp;
    logic cErr;
    logic pErr;
    logic [2:0] hIdx;
    logic plsIdx;
    logic [15:0] resLo;
    logic [15:0] resHi;
    logic [31:0] res32;
    pps_samp_t newSamp;
    logic [WIN_W-1:0] winLast;
    logic [31:0] mult;
    logic [31:0] limit;
    logic [CNT_W-1:0] cntNow;
    logic [31:0] prod;
    logic [15:0] portW;
    logic [15:0] codeW;
    // Latch in setup, or late in the access phase if setup was frozen
    latchNow = psel & (~penable | ~s_r.rdOk);
    // A transfer completes only once its answer has been latched
    doneAcc = psel & penable & s_r.rdOk;
    wrAcc = doneAcc & pwrite;
    execNow = 1'b0;
    isPls = 1'b0;
    isHsc = 1'b0;
    isHsc0 = 1'b0;
    isPwm = 1'b0;
    isSamp = 1'b0;
    cErr = 1'b0;
    pErr = 1'b0;
    hIdx = 3'h0;
    plsIdx = 1'b0;
    resLo = RST_WORD;
    resHi = RST_WORD;
    res32 = RST_FREQ;
    newSamp = s_r.samp;
    winLast = '0;
    mult = MULT_A;
    limit = FREQ_MAX_STD;
    cntNow = '0;
    prod = 32'h0000_0000;
    portW = s_r.port;
    codeW = s_r.code;
    // Everything not written below keeps its value
    s_nxt = s_r;

    // Register writes with byte lanes; take effect at the access edge
    // Only lanes 0 and 1 exist; upper lanes are ignored without error
    if (wrAcc) begin
      if (paddr == ADDR_PORT) begin
        if (pstrb[0]) begin
          portW[7:0] = pwdata[7:0];
        end
        if (pstrb[1]) begin
          portW[15:8] = pwdata[15:8];
        end
        s_nxt.port = portW;
      end
      if (paddr == ADDR_CODE) begin
        if (pstrb[0]) begin
          codeW[7:0] = pwdata[7:0];
        end
        if (pstrb[1]) begin
          codeW[15:8] = pwdata[15:8];
        end
        s_nxt.code = codeW;
      end
      execNow = (paddr == ADDR_EXEC);
    end

    // Read data and unmapped check latched one edge before completion;
    // reads have no side effects, so a late latch is harmless
    if (latchNow) begin
      s_nxt.rdOk = 1'b1;
      s_nxt.slverr = 1'b0;
      s_nxt.rdata = 32'h0000_0000;
      unique case (paddr)
        ADDR_PORT: s_nxt.rdata[15:0] = s_r.port;
        ADDR_CODE: s_nxt.rdata[15:0] = s_r.code;
        ADDR_EXEC: s_nxt.rdata = 32'h0000_0000;
        ADDR_DLO: s_nxt.rdata[15:0] = s_r.destLo;
        ADDR_DHI: s_nxt.rdata[15:0] = s_r.destHi;
        ADDR_FLAGS: s_nxt.rdata[FLAG_ERR_BIT] = s_r.err;
        default: s_nxt.slverr = 1'b1;
      endcase
    end
    // The handshake flag drops with the completing edge
    if (doneAcc) begin
      s_nxt.rdOk = 1'b0;
    end

    // Decode port and code held in the registers
    // hIdx is only used once the port is known to be a counter
    isPls = (s_r.port == PORT_PLS0) || (s_r.port == PORT_PLS1);
    plsIdx = s_r.port[0];
    isHsc = (s_r.port >= PORT_HSC0) && (s_r.port <= PORT_HSC_LAST);
    isHsc0 = (s_r.port == PORT_HSC0);
    isPwm = (s_r.port == PORT_PWM);
    hIdx = s_r.port[2:0];
    pErr = ~(isPls | isHsc | isPwm);
    isSamp = (s_r.code == CODE_S10) || (s_r.code == CODE_S100) ||
             (s_r.code == CODE_S1S);
    cErr = ~(isSamp || (s_r.code == CODE_PV) ||
             (s_r.code == CODE_STAT) || (s_r.code == CODE_RANGE) ||
             (s_r.code == CODE_FREQ));

    // Low two digits of the sampling code pick the window
    // Codes other than the three choices fall back to the shortest window
    unique case (s_r.code[7:0])
      CODE_S100[7:0]: newSamp = SAMP_100MS;
      CODE_S1S[7:0]: newSamp = SAMP_1S;
      default: newSamp = SAMP_10MS;
    endcase

    // Command execution; on error the destination keeps its old value
    if (execNow) begin
      s_nxt.err = 1'b0;
      // Every command clears the flag; only a refused one sets it
      if (pErr || cErr) begin
        s_nxt.err = 1'b1;
      end else if (isPls) begin
        if (s_r.code == CODE_STAT) begin
          resLo = plsWord[plsIdx];
        end else if (s_r.code == CODE_FREQ) begin
          res32 = plsFreqW[plsIdx];
          resLo = res32[15:0];
          resHi = res32[31:16];
        // Present value lives outside this block and reads as zero
        end else if (s_r.code != CODE_PV) begin
          s_nxt.err = 1'b1;
        end
      end else if (isPwm) begin
        // PWM reports only its output level
        if (s_r.code == CODE_STAT) begin
          resLo[PWM_OUT_BIT] = pwmOut;
        end else begin
          s_nxt.err = 1'b1;
        end
      // A port not set up as a counter refuses every code
      end else if (!hscEnabled[hIdx]) begin
        s_nxt.err = 1'b1;
      end else if (s_r.code == CODE_STAT) begin
        resLo = hscWord[hIdx];
      end else if (s_r.code == CODE_RANGE) begin
        // Range results only while range comparison runs
        if (hscRangeActive[hIdx]) begin
          resLo = rangeWord[hIdx];
        end else begin
          s_nxt.err = 1'b1;
        end
      end else if (isSamp) begin
        if (!isHsc0) begin
          s_nxt.err = 1'b1;
        end else begin
          // The read also picks the window for the coming measurements
          // Both halves from one 32-bit register, never torn
          resLo = s_r.freq[15:0];
          resHi = s_r.freq[31:16];
          s_nxt.samp = newSamp;
        end
      end else if (s_r.code == CODE_FREQ) begin
        s_nxt.err = 1'b1;
      end
      // A refused command leaves the destination words untouched
      if (!s_nxt.err) begin
        s_nxt.destLo = resLo;
        s_nxt.destHi = resHi;
      end
    end

    // ****************************************
    // Frequency measurement on counter 0
    // ****************************************
    // Short test windows keep the rate scaling of the full ones
    unique case (s_r.samp)
      SAMP_10MS: begin
        winLast = WIN_W'(WIN_A - 1);
        mult = MULT_A;
      end
      SAMP_100MS: begin
        winLast = WIN_W'(WIN_B - 1);
        mult = MULT_B;
      end
      SAMP_1S: begin
        winLast = WIN_W'(WIN_C - 1);
        mult = MULT_C;
      end
      default: begin
        winLast = WIN_W'(WIN_A - 1);
        mult = MULT_A;
      end
    endcase
    // Ceiling follows the input method when the window closes
    limit = hscQuad4x ? FREQ_MAX_QUAD : FREQ_MAX_STD;

    // Pulse count saturates so a long window cannot wrap
    // and report a small rate for a very fast input
    cntNow = s_r.pulseCnt;
    if (hscCount && (s_r.pulseCnt != CNT_CAP)) begin
      cntNow = s_r.pulseCnt + CNT_W'(1);
    end
    // A capped count times 100 still fits well inside 32 bits
    prod = 32'({14'h0000, cntNow} * mult);

    if (s_nxt.samp != s_r.samp) begin
      // New method: drop the half-done window
      // so no result ever mixes two window lengths
      s_nxt.winCnt = '0;
      s_nxt.pulseCnt = '0;
    end else if (s_r.winCnt >= winLast) begin
      // Clamp instead of wrap above the ceiling
      // The result is written whole, so both halves always match
      s_nxt.freq = (prod > limit) ? limit : prod;
      s_nxt.winCnt = '0;
      s_nxt.pulseCnt = '0;
    end else begin
      s_nxt.winCnt = s_r.winCnt + WIN_W'(1);
      s_nxt.pulseCnt = cntNow;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  // Clock enable low freezes everything, bus included
  // Asynchronous reset loads constants only
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_r <= '{port: RST_WORD, code: RST_WORD, destLo: RST_WORD,
               destHi: RST_WORD, err: 1'b0, rdata: RST_FREQ,
               slverr: 1'b0, rdOk: 1'b0, samp: SAMP_10MS, winCnt: '0,
               pulseCnt: '0, freq: RST_FREQ};
    end else if (clkEn) begin
      s_r <= s_nxt;
    end
  end

endmodule : pps_readout

//--- testbench/pps_checker.sv
// Checker for the readout block register and command behaviour
`timescale 1ns/100ps
module pps_checker
  import pps_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pps_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic [5:0] hscEnabled,
  input wire logic instructionErrorFlag
);
  // ********
  // Shadow of selector and code
  // ********
  logic [15:0] sel_r;
  logic [15:0] cod_r;
  logic acc, rd, exec, smp, err;
  assign acc = psel && penable && pready;
  assign rd = acc && !pwrite;
  assign exec = acc && pwrite && paddr == ADDR_EXEC;
  assign smp = cod_r == CODE_S10 || cod_r == CODE_S100 || cod_r == CODE_S1S;
  assign err = instructionErrorFlag;
  // Commands use what was last written, so mirror both writes
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sel_r <= RST_WORD;
      cod_r <= RST_WORD;
    end else if (acc && pwrite) begin
      if (paddr == ADDR_PORT && pstrb[0]) sel_r[7:0] <= pwdata[7:0];
      if (paddr == ADDR_PORT && pstrb[1]) sel_r[15:8] <= pwdata[15:8];
      if (paddr == ADDR_CODE && pstrb[0]) cod_r[7:0] <= pwdata[7:0];
      if (paddr == ADDR_CODE && pstrb[1]) cod_r[15:8] <= pwdata[15:8];
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  property p_statOk;
    exec && cod_r == CODE_STAT && sel_r <= PORT_PLS1 |=> !err;
  endproperty
  a_statOk: assert property (p_statOk) else $error("pulse status erred");
  property p_rangePls;
    exec && cod_r == CODE_RANGE && sel_r <= PORT_PLS1 |=> err;
  endproperty
  a_rangePls: assert property (p_rangePls) else $error("range ok");
  property p_pwmStat;
    exec && cod_r == CODE_STAT && sel_r == PORT_PWM |=> !err;
  endproperty
  a_pwmStat: assert property (p_pwmStat) else $error("pwm erred");
  property p_sampOk;
    exec && smp && sel_r == PORT_HSC0 && hscEnabled[0] |=> !err;
  endproperty
  a_sampOk: assert property (p_sampOk) else $error("sampling erred");
  property p_sampErr;
    exec && smp && sel_r != PORT_HSC0 |=> err;
  endproperty
  a_sampErr: assert property (p_sampErr) else $error("no error");
  property p_dhiCap;
    rd && paddr == ADDR_DHI |-> prdata[15:0] <= 16'h0003;
  endproperty
  a_dhiCap: assert property (p_dhiCap) else $error("above ceiling");
  property p_hiZero;
    rd && paddr <= ADDR_FLAGS |-> prdata[31:16] == 16'h0000;
  endproperty
  a_hiZero: assert property (p_hiZero) else $error("upper bits set");
  property p_errHold;
    !exec |=> $stable(err);
  endproperty
  a_errHold: assert property (p_errHold) else $error("flag moved");
  c_samp: cover property (exec && smp);
  c_err: cover property (exec ##1 err);
  c_dhi: cover property (rd && paddr == ADDR_DHI && prdata[15:0] != 16'h0000);
endmodule : pps_checker

bind pps_readout pps_checker chk (.clk_sys, .rst_b, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .hscEnabled,
  .instructionErrorFlag);

//--- testbench/pps_pulse_src.sv
// Pulse source model feeding counter 0 with one-cycle count strobes
`timescale 1ns/100ps
module pps_pulse_src (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [15:0] period,
  output logic hscCount
);
  logic [15:0] cnt_r;
  // Runs on without resetting the counter mid-window
  // A compare by >= survives a period cut while counting
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 16'h0000;
      hscCount <= 1'b0;
    end else if (period == 16'h0000) begin
      cnt_r <= 16'h0000;
      hscCount <= 1'b0;
    end else begin
      hscCount <= cnt_r >= period - 16'h0001;
      cnt_r <= (cnt_r >= period - 16'h0001) ? 16'h0000 : cnt_r + 16'h0001;
    end
  end
endmodule : pps_pulse_src

//--- testbench/testbench.sv
// Self-checking bench for the pulse port readout block
`timescale 1ns/100ps
module testbench;
  import pps_pkg::*;
  localparam int WA = 2100;
  localparam int WB = 200;
  localparam int WC = 2000;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic clkEn = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [1:0] pulseAccel = 2'h0, pulseOvf = 2'h0, pulseAmtSet = 2'h0;
  logic [1:0] pulseDone = 2'h0, pulseErrStop = 2'h0;
  logic [33:0] pulseFreq = 34'h0;
  logic [5:0] hscEnabled = 6'h0, hscRangeActive = 6'h0;
  logic [95:0] hscStatus = 96'h0;
  logic [35:0] hscRangeHit = 36'h0;
  logic hscQuad4x = 1'b0, hscCount, pwmOut = 1'b0;
  logic [31:0] prdata, rdat, lastD = 32'h0;
  logic pready, pslverr, instructionErrorFlag, serr;
  logic [15:0] per = 16'h0;
  int errors = 0, n_compared = 0;
  pps_readout #(.WIN_A(WA), .WIN_B(WB), .WIN_C(WC)) uut (.clk_sys, .rst_b,
    .clkEn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .pulseAccel, .pulseOvf, .pulseAmtSet, .pulseDone,
    .pulseErrStop, .pulseFreq, .hscEnabled, .hscStatus, .hscRangeActive,
    .hscRangeHit, .hscQuad4x, .hscCount, .pwmOut, .instructionErrorFlag);
  pps_pulse_src src (.clk_sys, .rst_b, .period(per), .hscCount);
  always #25 clk_sys = ~clk_sys;
  // ********
  // Bus, command and compare tasks
  // ********
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One APB transfer; idle cycle after it keeps drivers single per step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk_sys);
    end
    if (pready !== 1'b1) begin
      errors++;
      $display("[ERR] %0t no pready", $time);
    end
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  task automatic cmd(input logic [15:0] p, input logic [15:0] c);
    apb(1'b1, ADDR_PORT, {16'h0000, p});
    apb(1'b1, ADDR_CODE, {16'h0000, c});
    apb(1'b1, ADDR_EXEC, 32'h0);
  endtask : cmd
  // On error the destination must keep what the last good command left
  task automatic run(input logic [15:0] p, input logic [15:0] c,
                     input logic [31:0] d, input logic e);
    logic [15:0] lo;
    cmd(p, c);
    apb(1'b0, ADDR_DLO, 32'h0);
    lo = rdat[15:0];
    apb(1'b0, ADDR_DHI, 32'h0);
    if (!e) lastD = d;
    chk({rdat[15:0], lo}, lastD);
    apb(1'b0, ADDR_FLAGS, 32'h0);
    chk(rdat, {31'h0, e});
    chk({31'h0, instructionErrorFlag}, {31'h0, e});
  endtask : run
  task automatic t_bus;
    apb(1'b0, ADDR_FLAGS, 32'h0);
    chk(rdat, 32'h0);
    apb(1'b1, ADDR_DHI, 32'hFFFF);
    apb(1'b0, ADDR_DHI, 32'h0);
    chk(rdat, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk({31'h0, serr}, 32'h1);
    clkEn <= 1'b0;
    fork
      apb(1'b1, ADDR_PORT, 32'h15);
      begin
        repeat (3) @(posedge clk_sys);
        clkEn <= 1'b1;
      end
    join
    chk({31'h0, serr}, 32'h0);
    apb(1'b0, ADDR_PORT, 32'h0);
    chk(rdat, 32'h15);
    // Lane 0 only: the upper selector byte must keep its value
    pstrb <= 4'h1;
    apb(1'b1, ADDR_PORT, 32'hAB77);
    pstrb <= 4'hF;
    apb(1'b0, ADDR_PORT, 32'h0);
    chk(rdat, 32'h77);
  endtask : t_bus
  task automatic t_status;
    logic [4:0] c0;
    logic [4:0] c1;
    for (int i = 0; i < 2; i++) begin
      for (int b = 0; b < 5; b++) begin
        c0 = i ? ~(5'h01 << b) : 5'h01 << b;
        c1 = ~c0;
        pulseAccel <= {c1[0], c0[0]};
        pulseOvf <= {c1[1], c0[1]};
        pulseAmtSet <= {c1[2], c0[2]};
        pulseDone <= {c1[3], c0[3]};
        pulseErrStop <= {c1[4], c0[4]};
        run(16'(i), CODE_STAT, 32'h01 << b, 1'b0);
      end
    end
    hscEnabled <= 6'h09;
    hscStatus <= 96'hA5C3 << 48;
    pwmOut <= 1'b1;
    run(16'h0013, CODE_STAT, 32'hA5C3, 1'b0);
    run(16'h0014, CODE_STAT, 32'h0, 1'b1);
    run(PORT_PWM, CODE_STAT, 32'h1, 1'b0);
    pwmOut <= 1'b0;
    run(PORT_PWM, CODE_STAT, 32'h0, 1'b0);
    run(PORT_PWM, CODE_PV, 32'h0, 1'b1);
  endtask : t_status
  task automatic t_range;
    hscRangeActive <= 6'h01;
    hscRangeHit <= 36'hFED;
    pulseFreq <= {17'h1FFFF, 17'h01234};
    run(PORT_HSC0, CODE_RANGE, 32'h2D, 1'b0);
    run(PORT_PLS0, CODE_RANGE, 32'h0, 1'b1);
    run(16'h0013, CODE_RANGE, 32'h0, 1'b1);
    run(PORT_PLS0, CODE_FREQ, 32'h1234, 1'b0);
    run(PORT_PLS1, CODE_FREQ, 32'h186A0, 1'b0);
  endtask : t_range
  task automatic t_bad;
    logic [15:0] tp [6] = '{PORT_PLS0, 16'h0011, PORT_HSC0, 16'h0020,
                            PORT_PLS0, PORT_PWM};
    logic [15:0] tc [6] = '{CODE_S10, CODE_S100, CODE_FREQ, CODE_STAT,
                            16'h0004, CODE_S1S};
    hscEnabled <= 6'h3F;
    for (int k = 0; k < 6; k++) begin
      run(tp[k], tc[k], 32'h0, 1'b1);
    end
  endtask : t_bad
  // Waits two windows so the last finished one saw only the new rate
  task automatic t_samp;
    logic [15:0] tc [5] = '{CODE_S100, CODE_S1S, CODE_S10, CODE_S10,
                            CODE_S10};
    int tp [5] = '{4, 4, 4, 1, 1};
    int tw [5] = '{WB, WC, WA, WA, WA};
    int tm [5] = '{100, 1000, 10, 10, 10};
    int e;
    int lim;
    for (int k = 0; k < 5; k++) begin
      per <= 16'(tp[k]);
      hscQuad4x <= (k == 4);
      cmd(PORT_HSC0, tc[k]);
      repeat (2 * tw[k] + 10) @(posedge clk_sys);
      lim = (k == 4) ? 200000 : 100000;
      e = tw[k] / tp[k] * (1000 / tm[k]);
      run(PORT_HSC0, tc[k], 32'((e > lim) ? lim : e), 1'b0);
    end
  endtask : t_samp
  task automatic end_sim;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim
  // Main sequence
  initial begin
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    t_bus();
    t_status();
    t_range();
    t_bad();
    t_samp();
    end_sim();
  end
  // Watchdog well beyond the longest expected run
  initial begin
    #2000000;
    errors++;
    end_sim();
  end
endmodule : testbench
